// File: uimc_pkg.sv
// uimc_pkg: register offsets, field positions and reset values of the
// interrupt / modem-control block.
// assumes a 3-bit host address and 8-bit host data.
package uimc_pkg;

  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (rx buffer read / tx holding write share one)
  localparam logic [2:0] OFS_RXBUF   = 3'h0;
  localparam logic [2:0] OFS_IEN     = 3'h1;
  localparam logic [2:0] OFS_IDENT   = 3'h2;
  localparam logic [2:0] OFS_MCTL    = 3'h4;
  localparam logic [2:0] OFS_LSTAT   = 3'h5;
  localparam logic [2:0] OFS_MSTAT   = 3'h6;
  localparam logic [2:0] OFS_SCRATCH = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt_enable bits
  localparam int unsigned EN_RDA  = 0;
  localparam int unsigned EN_TX_HOLDING_EMPTY = 1;
  localparam int unsigned EN_LS   = 2;
  localparam int unsigned EN_MS   = 3;
  localparam int unsigned EN_W    = 4;

  // interrupt_ident codes in bits 2:1
  localparam logic [1:0] ID_LS   = 2'h3;
  localparam logic [1:0] ID_RDA  = 2'h2;
  localparam logic [1:0] ID_TX_HOLDING_EMPTY = 2'h1;
  localparam logic [1:0] ID_MS   = 2'h0;
  localparam logic [2:0] IDENT_RST = 3'h1;

  // modem_control bits
  localparam int unsigned MC_DTR  = 0;
  localparam int unsigned MC_RTS  = 1;
  localparam int unsigned MC_OUT1 = 2;
  localparam int unsigned MC_OUT2 = 3;
  localparam int unsigned MC_LOOP = 4;
  localparam int unsigned MC_W    = 5;

  // line_status bits
  localparam int unsigned LS_DR   = 0;
  localparam int unsigned LS_OE   = 1;
  localparam int unsigned LS_PE   = 2;
  localparam int unsigned LS_FE   = 3;
  localparam int unsigned LS_BI   = 4;
  localparam int unsigned LS_TX_HOLDING_EMPTY = 5;
  localparam int unsigned LS_TEMT = 6;

  // reset values
  localparam logic [7:0] REG_RST  = 8'h00;
  localparam logic       TX_HOLDING_EMPTY_RST = 1'b1;

endpackage : uimc_pkg

// File: uimc_irq_if.sv
// uimc_irq_if: carries the raw interrupt sources, enables and freeze
// request from the top to the priority encoder, and the ident back.
// assumes one clock domain.
`timescale 1ns/1ps
interface uimc_irq_if;
  logic [3:0] src;     // {ms, ls, tx_holding_empty, rda} raw pending
  logic [3:0] enable;  // interrupt_enable bits 3:0
  logic       freeze;  // ident read in progress
  logic [2:0] ident;   // {code, no_pending}

  modport ctl  (output src, output enable, output freeze, input ident);
  modport prio (input src, input enable, input freeze, output ident);
endinterface : uimc_irq_if

// File: uimc_prio.sv
// uimc_prio: ranks the enabled interrupt sources and holds the
// interrupt_ident value, frozen while the cpu reads it.
// assumes src bits are the block's sticky pending flags.
`timescale 1ns/1ps
module uimc_prio
  import uimc_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  // sources and ident
  uimc_irq_if.prio  irq
);

  logic [2:0] ident_d;
  logic [2:0] ident_q;
  logic [3:0] act;

  always_comb begin
    act     = irq.src & irq.enable;
    ident_d = ident_q;
    if (!irq.freeze) begin
      if (act[EN_LS])        ident_d = {ID_LS, 1'b0};
      else if (act[EN_RDA])  ident_d = {ID_RDA, 1'b0};
      else if (act[EN_TX_HOLDING_EMPTY]) ident_d = {ID_TX_HOLDING_EMPTY, 1'b0};
      else if (act[EN_MS])   ident_d = {ID_MS, 1'b0};
      else                   ident_d = IDENT_RST;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) ident_q <= IDENT_RST;
    else         ident_q <= ident_d;
  end

  assign irq.ident = ident_q;

endmodule : uimc_prio

// File: uimc_mstat.sv
// uimc_mstat: modem_status register: current line states and sticky
// change flags, with the loopback source swap.
// assumes modem pins are synchronous and active low.
`timescale 1ns/1ps
module uimc_mstat
  import uimc_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  // control
  input  wire logic       loop_i,
  input  wire logic [3:0] mctl_i,
  input  wire logic       clr_i,
  // pins {dcd, ri, dsr, cts}, active low
  input  wire logic [3:0] pins_n_i,
  // register value
  output logic      [7:0] status_o
);

  logic [3:0] state_d, state_q;
  logic [3:0] delta_d, delta_q;
  logic [3:0] chg;

  always_comb begin
    // loopback: cts<-rts, dsr<-dtr, ri<-out1, dcd<-out2
    if (loop_i) state_d = {mctl_i[MC_OUT2], mctl_i[MC_OUT1],
                           mctl_i[MC_DTR], mctl_i[MC_RTS]};
    else        state_d = ~pins_n_i;
    chg    = state_d ^ state_q;
    chg[2] = state_q[2] & ~state_d[2];
    // a change in the clearing cycle still sets
    delta_d = (clr_i ? 4'h0 : delta_q) | chg;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= 4'h0;
      delta_q <= 4'h0;
    end else begin
      state_q <= state_d;
      delta_q <= delta_d;
    end
  end

  assign status_o = {state_q, delta_q};

endmodule : uimc_mstat

// File: uimc_top.sv
// uimc_top: interrupt, modem control, loopback, modem status and
// scratch registers of an asynchronous serial unit.
// assumes host bus and unit strobes synchronous to core_clk_i; the
// baud, framing and line-control logic sit outside.
//
// Function
// - ident bit 0 is 0 when an enabled interrupt pends, else 1.
// - priority: line status, received data, tx holding empty, modem.
// - ident bits 2:1 carry 11, 10, 01, 00 for the winner.
// - line status irq from overrun/parity/framing/break, cleared by read.
// - tx empty irq cleared by ident read when shown or holding write.
// - ident stays frozen during its read, sources keep recording.
// - ident bits 7:3 read zero.
// - enable bits: 0 rx data, 1 tx empty, 2 line, 3 modem.
// - disabled interrupts hidden; status registers still update.
// - any enabled source raises the request; all off disables all.
// - dtr, rts, out1, out2 pins are inverse of control bits 0..3.
// - loop bit: serial out marks, serial in ignored, tx fed to rx.
// - loop: modem inputs from control bits, modem pins forced high.
// - loop: interrupts still work, modem sources are control bits.
// - modem_control bits 7:5 read zero.
// - modem status bits 0,1,3 set on cts, dsr, dcd change.
// - modem status bit 2 set on ring pin low-to-high.
// - reading modem status clears its four change bits.
// - any change bit set raises the modem status interrupt.
// - status bits 7:4 are inverted pins, or control bits in loop.
// - 8-bit scratch register, read/write, no other effect.
// - reading rx buffer clears data ready and its interrupt.
// - line status bits 1..4 are the line status irq sources.
// - tx empty set on holding-to-shift move, cleared on load.
`timescale 1ns/1ps
module uimc_top
  import uimc_pkg::*;
(
  // clock and reset
  input  wire logic                        core_clk_i,
  input  wire logic                        rstn_i,
  // host bus
  input  wire logic [uimc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic                        rd_i,
  input  wire logic                        wr_i,
  input  wire logic [uimc_pkg::DATA_W-1:0] wdata_i,
  output logic      [uimc_pkg::DATA_W-1:0] rdata_o,
  output logic                             interrupt_request_out_o,
  // modem pins, active low
  input  wire logic                        cts_n_i,
  input  wire logic                        dsr_n_i,
  input  wire logic                        ri_n_i,
  input  wire logic                        dcd_n_i,
  output logic                             dtr_n_o,
  output logic                             rts_n_o,
  output logic                             out1_n_o,
  output logic                             out2_n_o,
  // serial pins
  input  wire logic                        serial_in_pin_i,
  output logic                             serial_out_pin_o,
  // rest of the unit
  input  wire logic                        tx_shift_reg_out_i,
  output logic                             rx_shift_in_o,
  input  wire logic                        rx_char_done_i,
  input  wire logic [uimc_pkg::DATA_W-1:0] rx_data_i,
  input  wire logic                        overrun_i,
  input  wire logic                        parity_flag_i,
  input  wire logic                        framing_flag_i,
  input  wire logic                        break_flag_i,
  input  wire logic                        thr_to_tsr_i,
  input  wire logic                        tsr_empty_i,
  output logic                             tx_holding_load_o,
  output logic      [uimc_pkg::DATA_W-1:0] tx_holding_reg_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  uimc_irq_if irq ();

  logic [EN_W-1:0] ien_d, ien_q;
  logic [MC_W-1:0] mctl_d, mctl_q;
  logic [7:0]      scratch_d, scratch_q;
  logic [3:0]      lerr_d, lerr_q;     // {bi, fe, pe, oe}
  logic            dr_d, dr_q;
  logic            tx_holding_empty_d, tx_holding_empty_q;
  logic            tx_holding_empty_irq_d, tx_holding_empty_irq_q;
  logic            rd_d, rd_q;
  logic [2:0]      raddr_d, raddr_q;
  logic [7:0]      rdata_d, rdata_q;
  logic [7:0]      rxbuf_d, rxbuf_q;
  logic            interrupt_request_out_d, interrupt_request_out_q;
  logic [3:0]      mpin_d, mpin_q;     // {out2, out1, rts, dtr} pins
  logic            serial_out_pin_d, serial_out_pin_q;
  logic            rxin_d, rxin_q;
  logic            load_d, load_q;
  logic [7:0]      thr_d, thr_q;
  logic [7:0]      mstat;
  logic            rd_end;
  logic            wr_ok;
  logic            loop;

  // read side effects land when the access ends
  function automatic logic read_done(input logic [2:0] ofs);
    return rd_end && (raddr_q == ofs);
  endfunction : read_done

  function automatic logic wr_hit(input logic [2:0] ofs);
    return wr_ok && (addr_i == ofs);
  endfunction : wr_hit

  assign rd_end = rd_q & ~rd_i;
  assign wr_ok  = wr_i & ~rd_i;
  assign loop   = mctl_q[MC_LOOP];

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check

  // offsets, read mux and field slices are cut for this bus shape;
  // a wider bus needs the decode and the read mux reworked, so a
  // mismatch stops elaboration rather than truncating quietly
  if (ADDR_W != 3 || DATA_W != 8) begin : g_bus_check
    $error("uimc_top serves only a 3-bit address and 8-bit data bus");
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always_comb begin
    ien_d     = ien_q;
    mctl_d    = mctl_q;
    scratch_d = scratch_q;
    if (wr_hit(OFS_IEN))     ien_d     = wdata_i[EN_W-1:0];
    if (wr_hit(OFS_MCTL))    mctl_d    = wdata_i[MC_W-1:0];
    if (wr_hit(OFS_SCRATCH)) scratch_d = wdata_i;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ien_q     <= REG_RST[EN_W-1:0];
      mctl_q    <= REG_RST[MC_W-1:0];
      scratch_q <= REG_RST;
    end else begin
      ien_q     <= ien_d;
      mctl_q    <= mctl_d;
      scratch_q <= scratch_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line status and transmit flags; a set always beats a clear

  always_comb begin
    // line status writes are ignored: test-only on real silicon
    lerr_d = read_done(OFS_LSTAT) ? 4'h0 : lerr_q;
    lerr_d = lerr_d | {break_flag_i, framing_flag_i,
                       parity_flag_i, overrun_i};
    dr_d   = read_done(OFS_RXBUF) ? 1'b0 : dr_q;
    dr_d   = dr_d | rx_char_done_i;
    tx_holding_empty_d = wr_hit(OFS_RXBUF) ? 1'b0 : tx_holding_empty_q;
    tx_holding_empty_d = tx_holding_empty_d | thr_to_tsr_i;
    tx_holding_empty_irq_d = tx_holding_empty_irq_q;
    if (wr_hit(OFS_RXBUF))
      tx_holding_empty_irq_d = 1'b0;
    if (read_done(OFS_IDENT) && irq.ident == {ID_TX_HOLDING_EMPTY, 1'b0})
      tx_holding_empty_irq_d = 1'b0;
    // enabling the source while already empty also raises it
    if (thr_to_tsr_i || (wr_hit(OFS_IEN) && wdata_i[EN_TX_HOLDING_EMPTY]
                         && !ien_q[EN_TX_HOLDING_EMPTY] && tx_holding_empty_q))
      tx_holding_empty_irq_d = 1'b1;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lerr_q     <= 4'h0;
      dr_q       <= 1'b0;
      tx_holding_empty_q     <= TX_HOLDING_EMPTY_RST;
      tx_holding_empty_irq_q <= 1'b0;
    end else begin
      lerr_q     <= lerr_d;
      dr_q       <= dr_d;
      tx_holding_empty_q     <= tx_holding_empty_d;
      tx_holding_empty_irq_q <= tx_holding_empty_irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // modem status and interrupt ranking

  uimc_mstat u_mstat (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .loop_i     (loop),
    .mctl_i     (mctl_q[3:0]),
    .clr_i      (read_done(OFS_MSTAT)),
    .pins_n_i   ({dcd_n_i, ri_n_i, dsr_n_i, cts_n_i}),
    .status_o   (mstat)
  );

  assign irq.src[EN_LS]   = |lerr_q;
  assign irq.src[EN_RDA]  = dr_q;
  assign irq.src[EN_TX_HOLDING_EMPTY] = tx_holding_empty_irq_q;
  assign irq.src[EN_MS]   = |mstat[3:0];
  assign irq.enable       = ien_q;
  assign irq.freeze       = rd_i && (addr_i == OFS_IDENT);

  uimc_prio u_prio (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .irq        (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // access tracking; the address of the last read cycle is kept so that
  // its clear lands on the edge after the access, never in the middle

  always_comb begin
    rd_d    = rd_i;
    raddr_d = rd_i ? addr_i : raddr_q;
    rxbuf_d = rx_char_done_i ? rx_data_i : rxbuf_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // host read path; read data is registered, offset 3 is unmapped and
  // reads zero, and a held read refreshes all but the frozen ident

  always_comb begin
    rdata_d = rdata_q;
    if (rd_i) begin
      unique case (addr_i)
        OFS_RXBUF:   rdata_d = rxbuf_q;
        OFS_IEN:     rdata_d = {4'h0, ien_q};
        OFS_IDENT:   rdata_d = {5'h00, irq.ident};
        OFS_MCTL:    rdata_d = {3'h0, mctl_q};
        OFS_LSTAT:   rdata_d = {1'b0, tx_holding_empty_q & tsr_empty_i,
                                tx_holding_empty_q, lerr_q, dr_q};
        OFS_MSTAT:   rdata_d = mstat;
        OFS_SCRATCH: rdata_d = scratch_q;
        default:     rdata_d = REG_RST;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_q    <= 1'b0;
      raddr_q <= 3'h0;
      rdata_q <= REG_RST;
      rxbuf_q <= REG_RST;
    end else begin
      rd_q    <= rd_d;
      raddr_q <= raddr_d;
      rdata_q <= rdata_d;
      rxbuf_q <= rxbuf_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins, loopback and request output

  always_comb begin
    // pins idle high in loopback; the flags go to modem status
    mpin_d = loop ? 4'hf : ~mctl_q[3:0];
    serial_out_pin_d = loop ? 1'b1 : tx_shift_reg_out_i;
    rxin_d = loop ? tx_shift_reg_out_i : serial_in_pin_i;
    // raw flags, not the frozen ident, feed the request, so a long
    // ident read never hides a new one
    interrupt_request_out_d = |(irq.src & ien_q);
    load_d = wr_hit(OFS_RXBUF);
    thr_d  = wr_hit(OFS_RXBUF) ? wdata_i : thr_q;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mpin_q <= 4'hf;
      serial_out_pin_q <= 1'b1;
      rxin_q <= 1'b1;
      interrupt_request_out_q <= 1'b0;
      load_q <= 1'b0;
      thr_q  <= REG_RST;
    end else begin
      mpin_q <= mpin_d;
      serial_out_pin_q <= serial_out_pin_d;
      rxin_q <= rxin_d;
      interrupt_request_out_q <= interrupt_request_out_d;
      load_q <= load_d;
      thr_q  <= thr_d;
    end
  end

  assign dtr_n_o                 = mpin_q[MC_DTR];
  assign rts_n_o                 = mpin_q[MC_RTS];
  assign out1_n_o                = mpin_q[MC_OUT1];
  assign out2_n_o                = mpin_q[MC_OUT2];
  assign serial_out_pin_o        = serial_out_pin_q;
  assign rx_shift_in_o           = rxin_q;
  assign interrupt_request_out_o = interrupt_request_out_q;
  assign tx_holding_load_o       = load_q;
  assign tx_holding_reg_o        = thr_q;
  assign rdata_o                 = rdata_q;

endmodule : uimc_top

// File: uimc_monitor.sv
// uimc_monitor: port-level assertions for uimc_top.
// assumes one clock domain; it mirrors control writes to build expectations.
`timescale 1ns/1ps
module uimc_monitor
  import uimc_pkg::*;
(
  // clock, reset and host bus
  input wire logic                        core_clk_i,
  input wire logic                        rstn_i,
  input wire logic [uimc_pkg::ADDR_W-1:0] addr_i,
  input wire logic                        rd_i,
  input wire logic                        wr_i,
  input wire logic [uimc_pkg::DATA_W-1:0] wdata_i,
  input wire logic [uimc_pkg::DATA_W-1:0] rdata_o,
  input wire logic                        interrupt_request_out_o,
  // modem and serial pins
  input wire logic                        cts_n_i,
  input wire logic                        dsr_n_i,
  input wire logic                        dcd_n_i,
  input wire logic                        dtr_n_o,
  input wire logic                        rts_n_o,
  input wire logic                        out1_n_o,
  input wire logic                        out2_n_o,
  input wire logic                        serial_in_pin_i,
  input wire logic                        serial_out_pin_o,
  // rest of the unit
  input wire logic                        tx_shift_reg_out_i,
  input wire logic                        rx_shift_in_o,
  input wire logic                        overrun_i,
  input wire logic                        parity_flag_i,
  input wire logic                        framing_flag_i,
  input wire logic                        break_flag_i,
  input wire logic                        tx_holding_load_o,
  input wire logic [uimc_pkg::DATA_W-1:0] tx_holding_reg_o
);
  import uimc_pkg::*;
  logic [4:0] mc_q, mc_d;
  logic [3:0] ien_q, ien_d;
  logic [1:0] up_q, up_d;
  always_comb begin
    mc_d  = mc_q;
    ien_d = ien_q;
    up_d  = (up_q == 2'h3) ? up_q : up_q + 2'h1;
    if (wr_i && !rd_i && addr_i == OFS_MCTL) mc_d = wdata_i[4:0];
    if (wr_i && !rd_i && addr_i == OFS_IEN) ien_d = wdata_i[3:0];
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mc_q  <= 5'h00;
      ien_q <= 4'h0;
      up_q  <= 2'h0;
    end else begin
      mc_q  <= mc_d;
      ien_q <= ien_d;
      up_q  <= up_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence ident_rd_s;
    $rose(rd_i) && addr_i == OFS_IDENT;
  endsequence
  sequence ls_evt_s;
    (overrun_i || parity_flag_i || framing_flag_i || break_flag_i) && ien_q[EN_LS];
  endsequence
  // ring excluded: only its rising pin edge counts
  sequence ms_evt_s;
    $changed({cts_n_i, dsr_n_i, dcd_n_i}) && !mc_q[MC_LOOP] && ien_q[EN_MS] && up_q != 2'h0;
  endsequence
  sequence ident_held_s;
    (rd_i && addr_i == OFS_IDENT) [*2];
  endsequence
  pins_follow_a: assert property (mc_q == $past(mc_q) |->
    {out2_n_o, out1_n_o, rts_n_o, dtr_n_o} == (mc_q[MC_LOOP] ? 4'hf : ~mc_q[3:0]))
    else $error("modem pins differ from modem control");
  serial_out_pin_mark_a: assert property (up_q != 2'h0 |->
    serial_out_pin_o == ($past(mc_q[MC_LOOP]) || $past(tx_shift_reg_out_i)))
    else $error("serial out wrong");
  rx_feed_a: assert property (up_q != 2'h0 |-> rx_shift_in_o ==
    ($past(mc_q[MC_LOOP]) ? $past(tx_shift_reg_out_i) : $past(serial_in_pin_i)))
    else $error("receive shifter input wrong");
  ident_pend_a: assert property (ident_rd_s |=>
    rdata_o[7:3] == 5'h00 && rdata_o[0] == !$past(interrupt_request_out_o))
    else $error("ident pending bit wrong");
  mctl_read_a: assert property ($past(rd_i && addr_i == OFS_MCTL) |->
    rdata_o == {3'h0, $past(mc_q)}) else $error("modem control read wrong");
  ien_read_a: assert property ($past(rd_i && addr_i == OFS_IEN) |->
    rdata_o == {4'h0, $past(ien_q)}) else $error("enable read wrong");
  holding_load_a: assert property (wr_i && !rd_i && addr_i == OFS_RXBUF |=>
    tx_holding_load_o && tx_holding_reg_o == $past(wdata_i)) else $error("load missing");
  irq_off_a: assert property (ien_q == 4'h0 && $past(ien_q) == 4'h0 |->
    !interrupt_request_out_o) else $error("request with all enables off");
  ls_irq_a: assert property (ls_evt_s ##1 ien_q[EN_LS] |=>
    interrupt_request_out_o) else $error("line status request missing");
  ms_irq_a: assert property (ms_evt_s ##1 ien_q[EN_MS] [*2] |->
    ##[0:1] interrupt_request_out_o) else $error("modem request missing");
  ident_hold_a: assert property (ident_held_s |=> $stable(rdata_o))
    else $error("ident changed during its read");
endmodule : uimc_monitor

bind uimc_top uimc_monitor mon (.core_clk_i, .rstn_i, .addr_i, .rd_i, .wr_i, .wdata_i,
  .rdata_o, .interrupt_request_out_o, .cts_n_i, .dsr_n_i, .dcd_n_i, .dtr_n_o, .rts_n_o,
  .out1_n_o, .out2_n_o, .serial_in_pin_i, .serial_out_pin_o, .tx_shift_reg_out_i,
  .rx_shift_in_o, .overrun_i, .parity_flag_i, .framing_flag_i, .break_flag_i,
  .tx_holding_load_o, .tx_holding_reg_o);

// File: uimc_modem_model.sv
// uimc_modem_model: modem side: commanded pin levels, serial bits.
// assumes commands change just after a clock edge.
`timescale 1ns/1ps
module uimc_modem_model (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  // commanded levels {dcd, ri, dsr, cts}, active low
  input  wire logic [3:0] level_n_i,
  // pins and bit streams
  output logic      [3:0] pins_n_o,
  output logic            tx_bit_o,
  output logic            serial_in_o
);
  logic [3:0] pins_q;
  logic [1:0] pat_q;
  // tx bit toggles every cycle and serial in runs 0,1,1,0, so a stale path soon mismatches
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pins_q <= 4'hf;
      pat_q  <= 2'h0;
    end else begin
      pins_q <= level_n_i;
      pat_q  <= pat_q + 2'h1;
    end
  end
  assign pins_n_o    = pins_q;
  assign tx_bit_o    = pat_q[0];
  assign serial_in_o = ^pat_q;
endmodule : uimc_modem_model

// File: uimc_test.sv
// uimc_test: self-checking bench for uimc_top.
// assumes 40 MHz clock; reads are checked from a queue of notes.
`timescale 1ns/1ps
module uimc_test;
  import uimc_pkg::*;
  typedef struct {logic [2:0] a; logic [7:0] e;} uimc_note_t;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic       rd = 1'b0;
  logic       wr = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [7:0] rxd = 8'h00;
  logic [5:0] ev = 6'h00;
  logic [3:0] lvl = 4'hf;
  logic [7:0] rdata, tx_holding_reg, r;
  logic [3:0] mpin, opin;
  logic       irq, serial_out_pin, rxin, tx, serial_in_pin, ld;
  logic       took = 1'b0;
  int         mismatches = 0;
  int         total_checks = 0;
  int         seed = 30;
  uimc_note_t notes[$];
  uimc_note_t note;
  logic [2:0] rofs[6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
  logic [7:0] rexp[6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

  always #12.5 clk = ~clk;
  uimc_modem_model model (.core_clk_i(clk), .rstn_i(rstn), .level_n_i(lvl),
    .pins_n_o(mpin), .tx_bit_o(tx), .serial_in_o(serial_in_pin));
  uimc_top uut (.core_clk_i(clk), .rstn_i(rstn), .addr_i(addr), .rd_i(rd), .wr_i(wr),
    .wdata_i(wd), .rdata_o(rdata), .interrupt_request_out_o(irq), .cts_n_i(mpin[0]),
    .dsr_n_i(mpin[1]), .ri_n_i(mpin[2]), .dcd_n_i(mpin[3]), .dtr_n_o(opin[0]),
    .rts_n_o(opin[1]), .out1_n_o(opin[2]), .out2_n_o(opin[3]), .serial_in_pin_i(serial_in_pin),
    .serial_out_pin_o(serial_out_pin), .tx_shift_reg_out_i(tx), .rx_shift_in_o(rxin),
    .rx_char_done_i(ev[0]), .rx_data_i(rxd), .overrun_i(ev[1]), .parity_flag_i(ev[2]),
    .framing_flag_i(ev[3]), .break_flag_i(ev[4]), .thr_to_tsr_i(ev[5]),
    .tsr_empty_i(1'b1), .tx_holding_load_o(ld), .tx_holding_reg_o(tx_holding_reg));
  ////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr = a;
    wd   = d;
    wr   = 1'b1;
    cyc(1);
    wr   = 1'b0;
    cyc(1);
  endtask : wr_reg
  // two idle edges: the clear lands, then the ident settles
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
    notes.push_back('{a, e});
    addr = a;
    rd   = 1'b1;
    cyc(1);
    rd   = 1'b0;
    cyc(2);
  endtask : rd_reg
  task automatic pulse(input logic [5:0] v);
    ev = v;
    cyc(1);
    ev = 6'h00;
    cyc(4);
  endtask : pulse
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  always @(posedge clk) took <= rd;
  always @(negedge clk) begin
    if (took) begin
      note = notes.pop_front();
      chk($sformatf("offset %0h", note.a), note.e, rdata);
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(6);
    rstn = 1'b1;
    for (int i = 0; i < 6; i++) rd_reg(rofs[i], rexp[i]);
    chk("modem pins", 8'h0f, {4'h0, opin});
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      r = 8'($random(seed));
      wr_reg(OFS_SCRATCH, r);
      wr_reg(OFS_MCTL, r & 8'hef);
      wr_reg(OFS_IEN, r);
      rd_reg(OFS_SCRATCH, r);
      rd_reg(OFS_MCTL, r & 8'h0f);
      rd_reg(OFS_IEN, r & 8'h0f);
      chk("modem pins", {4'h0, ~r[3:0]}, {4'h0, opin});
    end
    wr_reg(OFS_MCTL, 8'h00);
    $display("register access done");
    wr_reg(OFS_IEN, 8'h0f);
    rxd = r;
    lvl = 4'he;
    pulse(6'h11);
    rd_reg(OFS_IDENT, 8'h06);
    rd_reg(OFS_LSTAT, 8'h71);
    rd_reg(OFS_IDENT, 8'h04);
    rd_reg(OFS_RXBUF, r);
    rd_reg(OFS_IDENT, 8'h02);
    rd_reg(OFS_IDENT, 8'h00);
    rd_reg(OFS_MSTAT, 8'h11);
    rd_reg(OFS_IDENT, 8'h01);
    chk("irq", 8'h00, {7'h0, irq});
    for (int i = 1; i < 4; i++) begin
      pulse(6'(1 << i));
      rd_reg(OFS_IDENT, 8'h06);
      rd_reg(OFS_LSTAT, 8'h60 | 8'(1 << i));
    end
    wr_reg(OFS_RXBUF, r);
    rd_reg(OFS_LSTAT, 8'h00);
    pulse(6'h20);
    chk("irq", 8'h01, {7'h0, irq});
    wr_reg(OFS_RXBUF, ~r);
    cyc(3);
    chk("irq", 8'h00, {7'h0, irq});
    $display("priority done");
    lvl = 4'hf;
    cyc(4);
    rd_reg(OFS_MSTAT, 8'h01);
    for (int i = 0; i < 4; i++) begin
      lvl = ~(4'h1 << i);
      cyc(4);
      rd_reg(OFS_MSTAT, (8'h10 << i) | (i == 2 ? 8'h00 : 8'h01 << i));
      lvl = 4'hf;
      cyc(4);
      rd_reg(OFS_MSTAT, 8'h01 << i);
      rd_reg(OFS_MSTAT, 8'h00);
    end
    $display("modem status done");
    wr_reg(OFS_IEN, 8'h00);
    pulse(6'h1e);
    chk("irq", 8'h00, {7'h0, irq});
    rd_reg(OFS_IDENT, 8'h01);
    rd_reg(OFS_LSTAT, 8'h1e);
    $display("disabled done");
    wr_reg(OFS_IEN, 8'h04);
    for (int i = 0; i < 5; i++) notes.push_back('{OFS_IDENT, 8'h01});
    addr = OFS_IDENT;
    rd   = 1'b1;
    pulse(6'h02);
    rd   = 1'b0;
    cyc(2);
    rd_reg(OFS_IDENT, 8'h06);
    rd_reg(OFS_LSTAT, 8'h02);
    $display("ident freeze done");
    wr_reg(OFS_IEN, 8'h08);
    wr_reg(OFS_MCTL, 8'h1f);
    lvl = 4'h0;
    cyc(4);
    chk("modem pins", 8'h0f, {4'h0, opin});
    rd_reg(OFS_IDENT, 8'h00);
    rd_reg(OFS_MSTAT, 8'hfb);
    lvl = 4'hf;
    wr_reg(OFS_MCTL, 8'h10);
    cyc(4);
    rd_reg(OFS_MSTAT, 8'h0f);
    wr_reg(OFS_MCTL, 8'h00);
    cyc(4);
    $display("loopback done");
    summarize();
  end
endmodule : uimc_test
